/* pkg/ssm_pkg.sv */
// Purpose: Shared constants for the sync serial master clocking block
// Assumes: Register port carries 16-bit words at word indices
// Notes: Half cpu clock unit is half a ref_clk period
package ssm_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 3;
	localparam logic [2:0] OFS_BAUD = 3'h0;
	localparam logic [2:0] OFS_CTRL = 3'h1;
	localparam logic [2:0] OFS_TX = 3'h2;
	localparam logic [2:0] OFS_RX = 3'h3;
	localparam logic [2:0] OFS_STAT = 3'h4;
	localparam int CTRL_PHASE_BIT = 0;
	localparam int CTRL_POL_BIT = 1;
	localparam int CTRL_PEC_BIT = 2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_RXFULL_BIT = 1;
	localparam int STAT_PHERR_BIT = 2;
	localparam logic [15:0] BAUD_RESET = 16'h0001;
	localparam logic [15:0] BAUD_MIN = 16'h0001;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam int REF_PERIOD_PS = 8000;
	localparam int HALF_CPU_UNIT_PS = REF_PERIOD_PS / 2;
	localparam int SCLK_PERIOD_UNITS = 4;
	localparam int HOLD_UNITS = 4;
	localparam int HOLD_CYC_RAW =
		(HOLD_UNITS * HALF_CPU_UNIT_PS + REF_PERIOD_PS - 1)
		/ REF_PERIOD_PS;
	localparam int HOLD_CYC = (HOLD_CYC_RAW < 1) ? 1 : HOLD_CYC_RAW;
	localparam int HALF_SCLK_UNITS = SCLK_PERIOD_UNITS / 2;
	localparam int HALF_SCLK_CYC_PER_STEP =
		(HALF_SCLK_UNITS * HALF_CPU_UNIT_PS) / REF_PERIOD_PS;
	typedef enum logic [0:0] {
		SSM_IDLE,
		SSM_RUN
	} ssm_state_t;
endpackage

/* verilog/ssm_baud_gen.sv */
// Purpose: Edge tick generator for the serial clock
// Assumes: Reload of zero is never presented, the register clamps it
// Notes: One tick per serial clock half period
`timescale 1ns/1ps
module ssm_baud_gen #(
	parameter int RELOAD_W = 16
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic run,
	input wire logic [RELOAD_W-1:0] reload,
	output logic tick
);
	logic [RELOAD_W-1:0] count_reg;
	logic [RELOAD_W-1:0] count_next;
	logic tick_next;
	wire atEnd = (count_reg == reload);

	// Half period is reload+1 cycles, so a full period is 4 units times
	// reload+1 with the unit at half a cycle
	assign count_next = (!run || atEnd) ? '0 : count_reg + 1'b1; // [RULE1]
	assign tick_next = run && atEnd; // [RULE1]

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			count_reg <= '0;
			tick <= 1'b0;
		end else if (clkEn) begin
			count_reg <= count_next;
			tick <= tick_next;
		end
	end
endmodule

/* verilog/ssm_master.sv */
// Purpose: Master clocking and bit timing of a sync serial channel
// Assumes: ref_clk is the cpu clock; the serial clock is made here
// Notes: Receive pin is synchronised, so latching lags two cycles
`timescale 1ns/1ps
//
// Contract
// [RULE1] Serial period is four units times reload plus one
// [RULE2] Reload spans 0001h to FFFFh, zero clamped
// [RULE3] Phase zero shifts leading, latches trailing edge
// [RULE4] Polarity zero idles low, leading edge rises
// [RULE5] Every bit of a word uses identical timing; in phase one the first bit is driven one cycle longer before its latch edge
// [RULE6] Phase error check enabled by one, off by zero
// [RULE7] Phase one swaps edges, polarity one idles high
module ssm_master #(
	parameter int WORD_W = ssm_pkg::DATA_W
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic [ssm_pkg::ADDR_W-1:0] regAddr,
	input wire logic [ssm_pkg::DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [ssm_pkg::DATA_W-1:0] regRdData,
	output logic sclkOut,
	output logic mosiOut,
	output logic selectN,
	input wire logic misoIn
);
	localparam int EDGE_W = $clog2(2 * WORD_W);
	localparam logic [EDGE_W-1:0] LAST_EDGE =
		EDGE_W'(2 * WORD_W - 1);
	localparam logic [1:0] HOLD_LAST = 2'(ssm_pkg::HOLD_CYC);

	ssm_pkg::ssm_state_t state_reg;
	ssm_pkg::ssm_state_t state_next;
	logic [15:0] baud_reg;
	logic [2:0] ctrl_reg;
	logic [WORD_W-1:0] txHold_reg;
	logic [WORD_W-1:0] txShift_reg;
	logic [WORD_W-1:0] txShift_next;
	logic [WORD_W-1:0] rxShift_reg;
	logic [WORD_W-1:0] rxShift_next;
	logic [WORD_W-1:0] rxData_reg;
	logic [EDGE_W-1:0] edge_reg;
	logic rxFull_reg;
	logic phErr_reg;
	logic misoMeta_reg;
	logic misoSync_reg;
	logic chkPend_reg;
	logic chkBit_reg;
	logic [1:0] chkCnt_reg;
	logic sclk_next;
	logic mosi_next;
	logic [ssm_pkg::DATA_W-1:0] rd_next;
	logic tick;

	function automatic logic [15:0] clampBaud(input logic [15:0] v);
		clampBaud = (v < ssm_pkg::BAUD_MIN) ? ssm_pkg::BAUD_MIN : v;
	endfunction

	function automatic logic [15:0] padWord(input logic [WORD_W-1:0] v);
		padWord = 16'(v);
	endfunction

	// Register decode
	wire selBaud = (regAddr == ssm_pkg::OFS_BAUD);
	wire selCtrl = (regAddr == ssm_pkg::OFS_CTRL);
	wire selTx = (regAddr == ssm_pkg::OFS_TX);
	wire selRx = (regAddr == ssm_pkg::OFS_RX);
	wire selStat = (regAddr == ssm_pkg::OFS_STAT);
	wire wrBaud = regWr && selBaud;
	wire wrCtrl = regWr && selCtrl;
	wire wrTx = regWr && selTx;
	wire wrStat = regWr && selStat;
	wire rdRx = regRd && selRx;

	wire phaseSel = ctrl_reg[ssm_pkg::CTRL_PHASE_BIT];
	wire polSel = ctrl_reg[ssm_pkg::CTRL_POL_BIT];
	wire pecEn = ctrl_reg[ssm_pkg::CTRL_PEC_BIT];
	wire busy = (state_reg == ssm_pkg::SSM_RUN);

	// A write while busy is dropped so the word in flight stays intact
	wire start = wrTx && !busy;

	// Even edges are leading, odd edges are trailing
	wire leadEdge = tick && !edge_reg[0];
	wire trailEdge = tick && edge_reg[0];
	wire shiftEdge = phaseSel ? trailEdge : leadEdge; // [RULE3] [RULE7]
	wire latchEdge = phaseSel ? leadEdge : trailEdge; // [RULE3] [RULE7]
	wire lastEdge = tick && (edge_reg == LAST_EDGE);
	// Phase one leaves the final trailing edge without a shift
	wire doShift = busy && shiftEdge && !(phaseSel && lastEdge);
	wire doLatch = busy && latchEdge;

	wire chkDone = chkPend_reg && (chkCnt_reg == HOLD_LAST);
	wire phErrSet = pecEn && chkDone && (misoSync_reg != chkBit_reg); // [RULE6]
	wire phErrClr = wrStat && regWrData[ssm_pkg::STAT_PHERR_BIT];
	wire rxFullSet = busy && lastEdge;

	wire [ssm_pkg::DATA_W-1:0] ctrlRead = 16'(ctrl_reg);
	wire [ssm_pkg::DATA_W-1:0] statRead = 16'({phErr_reg,
		rxFull_reg, busy});

	ssm_baud_gen #(
		.RELOAD_W(16)
	) uBaud (
		.ref_clk(ref_clk),
		.reset(reset),
		.clkEn(clkEn),
		.run(busy && !lastEdge),
		.reload(baud_reg),
		.tick(tick)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ssm_pkg::SSM_IDLE: begin
				if (start) begin
					state_next = ssm_pkg::SSM_RUN;
				end
			end
			ssm_pkg::SSM_RUN: begin
				if (lastEdge) begin
					state_next = ssm_pkg::SSM_IDLE;
				end
			end
			default: begin
				state_next = ssm_pkg::SSM_IDLE;
			end
		endcase
	end

	// Serial clock toggles each tick and parks at the idle level
	always_comb begin
		if (!busy || lastEdge) begin
			sclk_next = polSel; // [RULE4] [RULE7]
		end else if (tick) begin
			sclk_next = ~sclkOut; // [RULE1]
		end else begin
			sclk_next = sclkOut;
		end
	end

	// Phase one must present the first bit before the first edge
	always_comb begin
		mosi_next = mosiOut;
		txShift_next = txShift_reg;
		if (start && phaseSel) begin
			mosi_next = regWrData[WORD_W-1]; // [RULE7]
			txShift_next = regWrData[WORD_W-1:0] << 1;
		end else if (start) begin
			txShift_next = regWrData[WORD_W-1:0];
		end else if (doShift) begin
			mosi_next = txShift_reg[WORD_W-1]; // [RULE3] [RULE5]
			txShift_next = txShift_reg << 1;
		end
	end

	assign rxShift_next = doLatch ? // [RULE5]
		{rxShift_reg[WORD_W-2:0], misoSync_reg} : rxShift_reg;

	always_comb begin
		rd_next = '0;
		if (regRd) begin
			if (selBaud) begin
				rd_next = baud_reg;
			end else if (selCtrl) begin
				rd_next = ctrlRead;
			end else if (selTx) begin
				rd_next = padWord(txHold_reg);
			end else if (selRx) begin
				rd_next = padWord(rxData_reg);
			end else if (selStat) begin
				rd_next = statRead;
			end
		end
	end

	// Pin synchroniser: only the second stage is read by logic
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			misoMeta_reg <= 1'b0;
			misoSync_reg <= 1'b0;
		end else if (clkEn) begin
			misoMeta_reg <= misoIn;
			misoSync_reg <= misoMeta_reg;
		end
	end

	// Software registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			baud_reg <= ssm_pkg::BAUD_RESET;
			ctrl_reg <= ssm_pkg::CTRL_RESET;
			txHold_reg <= '0;
			regRdData <= '0;
		end else if (clkEn) begin
			if (wrBaud) begin
				baud_reg <= clampBaud(regWrData); // [RULE2]
			end
			if (wrCtrl) begin
				ctrl_reg <= regWrData[2:0]; // [RULE6] [RULE7]
			end
			if (start) begin
				txHold_reg <= regWrData[WORD_W-1:0];
			end
			regRdData <= rd_next;
		end
	end

	// Transfer engine
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= ssm_pkg::SSM_IDLE;
			edge_reg <= '0;
			txShift_reg <= '0;
			rxShift_reg <= '0;
			sclkOut <= 1'b0;
			mosiOut <= 1'b0;
			selectN <= 1'b1;
		end else if (clkEn) begin
			state_reg <= state_next;
			txShift_reg <= txShift_next;
			rxShift_reg <= rxShift_next;
			sclkOut <= sclk_next;
			mosiOut <= mosi_next;
			selectN <= !(state_next == ssm_pkg::SSM_RUN);
			if (start) begin
				edge_reg <= '0;
			end else if (busy && tick) begin
				edge_reg <= edge_reg + 1'b1; // [RULE5]
			end
		end
	end

	// Received word and sticky status; a set beats a same-cycle clear
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rxData_reg <= '0;
			rxFull_reg <= 1'b0;
			phErr_reg <= 1'b0;
		end else if (clkEn) begin
			if (rxFullSet) begin
				rxData_reg <= rxShift_next;
				rxFull_reg <= 1'b1;
			end else if (rdRx) begin
				rxFull_reg <= 1'b0;
			end
			if (phErrSet) begin
				phErr_reg <= 1'b1; // [RULE6]
			end else if (phErrClr) begin
				phErr_reg <= 1'b0;
			end
		end
	end

	// Hold check: the pin must still show the latched bit a fixed
	// time after the latch edge; both samples share the same lag
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			chkPend_reg <= 1'b0;
			chkBit_reg <= 1'b0;
			chkCnt_reg <= '0;
		end else if (clkEn) begin
			if (doLatch && pecEn) begin
				chkPend_reg <= 1'b1; // [RULE6]
				chkBit_reg <= misoSync_reg;
				chkCnt_reg <= 2'h1;
			end else if (chkDone) begin
				chkPend_reg <= 1'b0;
				chkCnt_reg <= '0;
			end else if (chkPend_reg) begin
				chkCnt_reg <= chkCnt_reg + 2'h1;
			end
		end
	end
endmodule

/* bench/ssm_master_assertions.sv */
// Purpose: Port checks for ssm_master
// Assumes: Baud and ctrl are shadowed from register writes
// Notes: Last half period ends with select, so it is not timed
`timescale 1ns/1ps
module ssm_master_chk #(parameter int WORD_W = 16) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic [2:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [15:0] regRdData,
	input wire logic sclkOut,
	input wire logic mosiOut,
	input wire logic selectN,
	input wire logic misoIn
);
	logic polReg, phaReg, sclkPrev, selPrev;
	logic [15:0] baudReg;
	int gapReg, edgeReg;
	wire logic wrOk = regWr && clkEn;
	wire logic wrCtrl = wrOk && regAddr == ssm_pkg::OFS_CTRL;
	wire logic wrBaud = wrOk && regAddr == ssm_pkg::OFS_BAUD;
	wire logic [15:0] baudNext = (regWrData == 16'h0) ? 16'h1 : regWrData;
	wire logic sclkMoved = sclkOut != sclkPrev;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			polReg <= 1'b0;
			phaReg <= 1'b0;
			baudReg <= 16'h1;
		end else if (wrCtrl) begin
			phaReg <= regWrData[0];
			polReg <= regWrData[1];
		end else if (wrBaud) begin
			baudReg <= baudNext;
		end
	end
	// Frame edge count restarts at select so idle moves are ignored
	always_ff @(posedge ref_clk) begin
		sclkPrev <= sclkOut;
		selPrev <= selectN;
		gapReg <= sclkMoved ? 1 : gapReg + 1;
		if (!selectN && selPrev)
			edgeReg <= 0;
		else if (sclkMoved)
			edgeReg <= edgeReg + 1;
	end
	sequence s_zero;
		wrBaud && regWrData == 16'h0;
	endsequence
	sequence s_rdBaud;
		regRd && regAddr == ssm_pkg::OFS_BAUD;
	endsequence
	property p_idle;
		selectN && $stable(polReg) |-> sclkOut == polReg;
	endproperty
	a_idle: assert property (p_idle) else $error("idle level");
	property p_half;
		$changed(sclkOut) && !selectN && edgeReg > 0 |->
			gapReg == baudReg + 1;
	endproperty
	a_half: assert property (p_half) else $error("half period");
	property p_clamp;
		s_zero ##2 s_rdBaud |=> regRdData == 16'h0001;
	endproperty
	a_clamp: assert property (p_clamp) else $error("clamp");
	property p_ph0;
		$changed(mosiOut) && !selectN && !$past(selectN) && !phaReg |->
			$changed(sclkOut) && sclkOut != polReg;
	endproperty
	a_ph0: assert property (p_ph0) else $error("phase 0 shift");
	property p_ph1;
		$changed(mosiOut) && !selectN && !$past(selectN) && phaReg |->
			$changed(sclkOut) && sclkOut == polReg;
	endproperty
	a_ph1: assert property (p_ph1) else $error("phase 1 shift");
	property p_count;
		$rose(selectN) |=> edgeReg == 2 * WORD_W;
	endproperty
	a_count: assert property (p_count) else $error("edge count");
	property p_start;
		wrOk && regAddr == ssm_pkg::OFS_TX && selectN |=> !selectN;
	endproperty
	a_start: assert property (p_start) else $error("no start");
endmodule
bind ssm_master ssm_master_chk #(.WORD_W(WORD_W)) chk (
	.ref_clk(ref_clk), .reset(reset), .clkEn(clkEn), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
	.regRdData(regRdData), .sclkOut(sclkOut), .mosiOut(mosiOut),
	.selectN(selectN), .misoIn(misoIn)
);

/* bench/ssm_slave.sv */
// Purpose: Serial slave at the link pins
// Assumes: Told the mode by the bench
// Notes: Released data line shows the inverse of its last bit
`timescale 1ns/1ps
module ssm_slave (
	input wire logic sclk,
	input wire logic selN,
	input wire logic mosi,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [15:0] txWord,
	output logic miso,
	output logic [15:0] rxWord
);
	int idx = -1;
	initial miso = 1'b0;
	always @(negedge selN) begin
		idx = 15;
		if (cpha) begin
			miso = txWord[15];
			idx = 14;
		end
	end
	always @(posedge selN) miso = ~miso;
	// Latch on trailing edge in phase 0, leading in phase 1
	always @(sclk) begin
		if ((sclk != cpol) == cpha)
			rxWord = {rxWord[14:0], mosi};
		else if (idx >= 0) begin
			miso = txWord[idx[3:0]];
			idx--;
		end
	end
endmodule

/* bench/ssm_master_bench.sv */
// Purpose: Self-checking bench for ssm_master
// Assumes: Slave model on the serial pins
// Notes: Serial clock comes from the block, so one clock only
`timescale 1ns/1ps
module ssm_master_bench;
	logic ref_clk = 0, reset = 1, regWr = 0, regRd = 0, miso, cpol = 0;
	logic cpha = 0, sclkOut, mosiOut, selectN;
	logic [2:0] regAddr = 0;
	logic [15:0] regWrData = 0, regRdData, slvTx = 0, slvRx;
	int nMismatch = 0, cmpCount = 0;
	always #4 ref_clk = ~ref_clk;
	ssm_master DUT (.ref_clk(ref_clk), .reset(reset), .clkEn(1'b1),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .sclkOut(sclkOut),
		.mosiOut(mosiOut), .selectN(selectN), .misoIn(miso));
	ssm_slave slave (.sclk(sclkOut), .selN(selectN), .mosi(mosiOut),
		.cpol(cpol), .cpha(cpha), .txWord(slvTx), .miso(miso),
		.rxWord(slvRx));
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmpCount, nMismatch);
		if (nMismatch == 0 && cmpCount > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			nMismatch++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
		// One idle edge so back to back writes never drive the strobe twice
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 chk(regRdData, e);
		@(posedge ref_clk);
	endtask
	// Slow rx sampling below baud 2 would race the synchroniser
	task automatic xfer(input logic [2:0] c, input logic [15:0] b, w,
		input bit rx);
		int gap, edges, n;
		logic last;
		cpha <= c[0];
		cpol <= c[1];
		slvTx <= ~w;
		wr(ssm_pkg::OFS_BAUD, b);
		wr(ssm_pkg::OFS_CTRL, {13'h0, c});
		wr(ssm_pkg::OFS_TX, w);
		gap = 0;
		edges = 0;
		last = sclkOut;
		for (n = 0; n < 3000 && !(edges > 0 && selectN); n++) begin
			@(posedge ref_clk);
			#1 gap++;
			if (sclkOut !== last) begin
				if (edges > 0 && !selectN)
					chk(16'(gap), b + 16'h1);
				edges++;
				gap = 0;
				last = sclkOut;
			end
		end
		chk(16'(edges), 16'(2 * ssm_pkg::DATA_W));
		chk(16'(sclkOut), 16'(c[1]));
		chk(slvRx, w);
		@(posedge ref_clk);
		if (rx)
			rd(ssm_pkg::OFS_RX, ~w);
		rd(ssm_pkg::OFS_STAT, rx ? 16'h0 : {13'h0, c[2], 2'h2});
		$display("transfer mode %h done", c);
	endtask
	task automatic reg_test();
		rd(ssm_pkg::OFS_BAUD, 16'h0001);
		rd(ssm_pkg::OFS_CTRL, 16'h0000);
		chk(16'(selectN), 16'h1);
		wr(ssm_pkg::OFS_BAUD, 16'hffff);
		rd(ssm_pkg::OFS_BAUD, 16'hffff);
		wr(ssm_pkg::OFS_BAUD, 16'h0000);
		rd(ssm_pkg::OFS_BAUD, 16'h0001);
		$display("register test done");
	endtask
	// Fastest baud leaves the slave too little setup, so the check trips
	task automatic pec_test();
		xfer(3'h4, 16'h1, 16'h3c96, 1'b0);
		wr(ssm_pkg::OFS_STAT, 16'h0004);
		rd(ssm_pkg::OFS_STAT, 16'h0002);
		$display("phase error test done");
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		reg_test();
		for (int m = 0; m < 8; m++)
			xfer(m[2:0], 16'h2, 16'ha5c3 ^ m[15:0], 1'b1);
		xfer(3'h0, 16'h1, 16'h3c96, 1'b0);
		pec_test();
		conclude();
	end
	initial begin
		#200000;
		nMismatch++;
		conclude();
	end
endmodule
